// [design/adcsc_top.sv]
// Overview of operation
// RULE1 - result msbs upper byte, lsbs bits 7:6
// RULE2 - lower byte bits 5:0 read zero
// RULE3 - results cleared by reset and standby
// RULE4 - group position selects result a to d
// RULE5 - done flag set at sequence end
// RULE6 - clear done by read-one then write-zero
// RULE7 - dma result read clears done flag
// RULE8 - irq enable gates conversion end request
// RULE9 - software changes irq enable only idle
// RULE10 - single mode go self clears at end
// RULE11 - multi mode go clears after all channels
// RULE12 - scan repeats until go cleared
// RULE13 - external trigger sets go like software
// RULE14 - mode from multi and cyclic bits
// RULE15 - time select 536 or 266 states
// RULE16 - software stops before changing selection
// RULE17 - single mode channel field picks input
// RULE18 - multi group bit and channel count
// RULE19 - both trigger enables arm falling edge
// RULE20 - software changes trigger enables only idle
// RULE21 - trigger reg bits 4:3 zero, 2:0 one
// RULE22 - control resets 00, trigger 07
// RULE23 - upper byte read latches lower byte
// RULE24 - scan pass sets done and restarts
// RULE25 - irq is done and enable, held
`include "adcsc_map.svh"
module adcsc_top
    import adcsc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic standby,
    input wire logic [4:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic dma_read,
    input wire logic ext_trigger_pin,
    output logic conv_req,
    output logic [2:0] conv_chan,
    output logic conv_time_sel,
    input wire logic conv_ack,
    input wire logic [RES_W-1:0] conv_data,
    output logic conv_end_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    adcsc_state_t state, next_state;
    logic [7:0] csr, next_csr;
    logic [2:0] trg, next_trg;
    logic [RES_W-1:0] res [4];
    logic [RES_W-1:0] next_res [4];
    logic [7:0] hold, next_hold;
    logic [1:0] pos, next_pos;
    logic trig_q, next_trig_q;
    logic done_seen, next_done_seen;
    logic [7:0] next_rdata;
    logic next_req;
    logic [2:0] next_chan;
    logic next_irq;
    adcsc_mode_t mode;
    logic fall, go_set, go_now, last;
    logic [2:0] cur_chan;
    logic [7:0] trg_rd;
    localparam logic [7:0] TRG_RST = `ADCSC_TRG_RESET;

    // trg holds bits 7:5, so trg[0] is the cyclic bit
    assign mode = adcsc_mode_t'({trg[0], csr[`ADCSC_CSR_MULTI]}); // RULE14
    // only the 11 enable pair arms the pin; mixed pairs stay disarmed
    assign fall = trig_q & ~ext_trigger_pin & trg[2] & trg[1]; // RULE19
    assign go_set = (bus_wr && bus_addr == `ADCSC_OFS_CSR
        && bus_wdata[`ADCSC_CSR_GO]) || fall; // RULE13
    assign cur_chan = (mode == ADCSC_SINGLE) ? csr[2:0]
        : {csr[2], pos}; // RULE17 RULE18
    assign last = (mode == ADCSC_SINGLE) || (pos == csr[1:0]); // RULE18
    assign trg_rd = {trg, 2'b00, `ADCSC_TRG_ONES}; // RULE21
    assign go_now = csr[`ADCSC_CSR_GO];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_csr = csr;
        next_trg = trg;
        next_hold = hold;
        next_pos = pos;
        next_done_seen = done_seen;
        next_trig_q = ext_trigger_pin;
        next_rdata = 8'h00;
        for (int i = 0; i < 4; i++) begin
            next_res[i] = res[i];
        end
        // register reads; upper byte read latches lower byte
        if (bus_rd) begin
            case (bus_addr)
                `ADCSC_OFS_CSR: begin
                    next_rdata = csr;
                    next_done_seen = csr[`ADCSC_CSR_DONE]; // RULE6
                end
                `ADCSC_OFS_TRG: next_rdata = trg_rd;
                default: begin
                    if (bus_addr[4] == 1'b0 && bus_addr[0] == 1'b0) begin
                        if (bus_addr[1] == 1'b0) begin
                            next_rdata = res[bus_addr[3:2]][RES_W-1:2]; // RULE1
                            next_hold = {res[bus_addr[3:2]][1:0],
                                6'h00}; // RULE23 RULE2
                        end else begin
                            next_rdata = hold; // RULE23
                        end
                    end
                end
            endcase
        end
        if (bus_wr && bus_addr == `ADCSC_OFS_CSR) begin
            next_csr[6:0] = bus_wdata[6:0];
            // a write of one to the flag is ignored
            if (!bus_wdata[`ADCSC_CSR_DONE] && done_seen) begin
                next_csr[`ADCSC_CSR_DONE] = 1'b0; // RULE6
                next_done_seen = 1'b0;
            end
        end
        if (bus_wr && bus_addr == `ADCSC_OFS_TRG) begin
            next_trg = bus_wdata[7:5]; // RULE21
        end
        if (dma_read) begin
            next_csr[`ADCSC_CSR_DONE] = 1'b0; // RULE7
        end
        if (fall) begin
            next_csr[`ADCSC_CSR_GO] = 1'b1; // RULE13
        end
        case (state)
            ADCSC_IDLE: begin
                next_pos = 2'b00;
                if (go_set && mode != ADCSC_UNDEF) begin
                    next_state = ADCSC_WAIT;
                end
            end
            ADCSC_WAIT: begin
                if (!go_now) begin
                    next_state = ADCSC_IDLE; // RULE12
                end else if (conv_ack) begin
                    next_res[(mode == ADCSC_SINGLE) ? csr[1:0] : pos] =
                        conv_data; // RULE4 RULE1
                    if (last) begin
                        // set beats a dma or write-zero clear in the same cycle; standby still wins
                        next_csr[`ADCSC_CSR_DONE] = 1'b1; // RULE5
                        next_done_seen = 1'b0;
                        next_pos = 2'b00;
                        if (mode == ADCSC_SCAN) begin
                            next_state = ADCSC_NEXT; // RULE24
                        end else begin
                            next_csr[`ADCSC_CSR_GO] = 1'b0; // RULE10 RULE11
                            next_state = ADCSC_IDLE;
                        end
                    end else begin
                        next_pos = pos + 2'b01;
                        next_state = ADCSC_NEXT;
                    end
                end
            end
            ADCSC_NEXT: begin
                // one gap cycle so the core sees request drop
                next_state = go_now ? ADCSC_WAIT : ADCSC_IDLE; // RULE12
            end
            default: next_state = ADCSC_IDLE;
        endcase
        // standby clears state, control, trigger, position and results like a reset
        if (standby) begin
            next_state = ADCSC_IDLE;
            next_csr = `ADCSC_CSR_RESET; // RULE22
            next_trg = TRG_RST[7:5]; // RULE22
            next_pos = 2'b00;
            next_done_seen = 1'b0;
            for (int i = 0; i < 4; i++) begin
                next_res[i] = '0; // RULE3
            end
        end
    end

    always_comb begin
        next_req = (next_state == ADCSC_WAIT);
        next_chan = (next_trg[0] == 1'b0 && !next_csr[`ADCSC_CSR_MULTI])
            ? next_csr[2:0] : {next_csr[2], next_pos}; // RULE17 RULE18
        next_irq = next_csr[`ADCSC_CSR_DONE]
            & next_csr[`ADCSC_CSR_IRQEN]; // RULE8 RULE25
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ADCSC_IDLE;
            csr <= `ADCSC_CSR_RESET; // RULE22
            trg <= 3'h0;
            hold <= 8'h00;
            pos <= 2'b00;
            trig_q <= 1'b1;
            done_seen <= 1'b0;
            bus_rdata <= 8'h00;
            conv_req <= 1'b0;
            conv_chan <= 3'h0;
            conv_time_sel <= 1'b0;
            conv_end_irq <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                res[i] <= '0; // RULE3
            end
        end else begin
            state <= next_state;
            csr <= next_csr;
            trg <= next_trg;
            hold <= next_hold;
            pos <= next_pos;
            trig_q <= next_trig_q;
            done_seen <= next_done_seen;
            bus_rdata <= next_rdata;
            conv_req <= next_req;
            conv_chan <= next_chan;
            conv_time_sel <= next_csr[`ADCSC_CSR_TSEL]; // RULE15
            conv_end_irq <= next_irq;
            for (int i = 0; i < 4; i++) begin
                res[i] <= next_res[i];
            end
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_irq_tracks_flag: assert property ( // RULE25
        conv_end_irq == (csr[7] & csr[6]))
        else $error("irq not equal to flag and enable");
    chk_done_sets_flag: assert property ( // RULE5
        state == ADCSC_WAIT && go_now && conv_ack && last && !standby
        |=> csr[7])
        else $error("done flag not set at sequence end");
    chk_single_go_clears: assert property ( // RULE10
        state == ADCSC_WAIT && go_now && conv_ack && mode == ADCSC_SINGLE
        && !fall |=> !csr[5] && state == ADCSC_IDLE)
        else $error("single mode go did not clear");
    chk_scan_restart: assert property ( // RULE24
        state == ADCSC_WAIT && go_now && conv_ack && last && !standby
        && mode == ADCSC_SCAN && !(bus_wr && bus_addr == `ADCSC_OFS_CSR)
        |=> pos == 2'b00 && csr[5])
        else $error("scan did not restart");
    chk_write_one_ign: assert property ( // RULE6
        !csr[7] && !(state == ADCSC_WAIT && conv_ack) |=> !csr[7])
        else $error("done flag set by write");
    chk_trg_readback: assert property ( // RULE21
        bus_rd && bus_addr == `ADCSC_OFS_TRG |=> bus_rdata[4:0] == 5'h07)
        else $error("trigger reserved bits wrong");
    chk_lo_reserved: assert property ( // RULE2
        bus_rd && bus_addr == 5'(`ADCSC_OFS_RES_A_LO)
        |=> bus_rdata[5:0] == 6'h00)
        else $error("lower byte reserved bits nonzero");
    chk_standby_clear: assert property ( // RULE3
        standby |=> csr == 8'h00 && res[0] == '0 && res[3] == '0)
        else $error("standby did not clear");
    chk_dma_clear: assert property ( // RULE7
        dma_read && !(state == ADCSC_WAIT && conv_ack) |=> !csr[7])
        else $error("dma read did not clear flag");
    chk_chan_follows: assert property ( // RULE17 RULE18
        conv_req |-> conv_chan == cur_chan)
        else $error("converter channel does not follow selection");
    chk_tsel_follows: assert property ( // RULE15
        conv_req |-> conv_time_sel == csr[3])
        else $error("time select does not follow control bit");
    chk_multi_go_holds: assert property ( // RULE11
        state == ADCSC_WAIT && go_now && conv_ack && !last && !standby
        && !(bus_wr && bus_addr == `ADCSC_OFS_CSR) |=> csr[5])
        else $error("go cleared before last channel");
    chk_undef_refused: assert property ( // RULE14
        state == ADCSC_IDLE && mode == ADCSC_UNDEF && !standby
        |=> state == ADCSC_IDLE)
        else $error("undefined mode started a conversion");
    chk_trig_starts: assert property ( // RULE13 RULE19
        fall && state == ADCSC_IDLE && mode != ADCSC_UNDEF && !standby
        |=> csr[5] && conv_req)
        else $error("external trigger did not start");
    chk_mixed_no_trig: assert property ( // RULE19
        state == ADCSC_IDLE && !csr[5] && !standby && !bus_wr
        && trg[2:1] != 2'b11 |=> !csr[5])
        else $error("disarmed trigger set go");

    // ----------------------------------------
    // scenario covers
    // ----------------------------------------
    cov_single: cover property (state == ADCSC_WAIT && conv_ack
        && mode == ADCSC_SINGLE);
    cov_multi_end: cover property (state == ADCSC_WAIT && conv_ack && last
        && mode == ADCSC_MULTI);
    cov_scan_wrap: cover property (state == ADCSC_NEXT && mode == ADCSC_SCAN
        && pos == 2'b00);
    cov_ext_trig: cover property (fall);
    cov_dma_clear: cover property (dma_read && csr[7]);
endmodule

// [design/adcsc_map.svh]
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADCSC_OFS_RES_A_HI 4'h0
`define ADCSC_OFS_RES_A_LO 4'h2
`define ADCSC_OFS_RES_B_HI 4'h4
`define ADCSC_OFS_RES_B_LO 4'h6
`define ADCSC_OFS_RES_C_HI 4'h8
`define ADCSC_OFS_RES_C_LO 4'ha
`define ADCSC_OFS_RES_D_HI 4'hc
`define ADCSC_OFS_RES_D_LO 4'he
`define ADCSC_OFS_CSR 5'h10
`define ADCSC_OFS_TRG 5'h12
// ----------------------------------------
// control/status fields
// ----------------------------------------
`define ADCSC_CSR_DONE 7
`define ADCSC_CSR_IRQEN 6
`define ADCSC_CSR_GO 5
`define ADCSC_CSR_MULTI 4
`define ADCSC_CSR_TSEL 3
`define ADCSC_CSR_RESET 8'h00
// ----------------------------------------
// trigger control fields
// ----------------------------------------
`define ADCSC_TRG_EN_HI 7
`define ADCSC_TRG_EN_LO 6
`define ADCSC_TRG_CYCLIC 5
`define ADCSC_TRG_RESET 8'h07
`define ADCSC_TRG_ONES 3'h7
// ----------------------------------------
// timing, in converter states
// ----------------------------------------
`define ADCSC_TCONV_SLOW 536
`define ADCSC_TCONV_FAST 266
`endif

// [design/adcsc_pkg.sv]
package adcsc_pkg;
    typedef enum logic [1:0] {
        ADCSC_IDLE = 2'b00,
        ADCSC_WAIT = 2'b01,
        ADCSC_NEXT = 2'b10
    } adcsc_state_t;
    typedef enum logic [1:0] {
        ADCSC_SINGLE = 2'b00,
        ADCSC_MULTI = 2'b01,
        ADCSC_SCAN = 2'b11,
        ADCSC_UNDEF = 2'b10
    } adcsc_mode_t;
endpackage

// [test/adcsc_core_model.sv]
// --------------------------------------------
// converter core stand-in
// --------------------------------------------
module adcsc_core_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic conv_req,
    input wire logic [2:0] conv_chan,
    input wire logic conv_time_sel,
    input wire logic [6:0] salt,
    output logic conv_ack,
    output logic [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt;
    logic [9:0] last;
    // short counts stand in for the long state counts to keep runs brief
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 5'h00;
            conv_ack <= 1'b0;
            last <= 10'h000;
        end else if (conv_req && !conv_ack) begin
            if (cnt == (conv_time_sel ? 5'h03 : 5'h07)) begin
                conv_ack <= 1'b1;
                last <= {salt, conv_chan};
                cnt <= 5'h00;
            end else begin
                cnt <= cnt + 5'h01;
            end
        end else begin
            conv_ack <= 1'b0;
            cnt <= 5'h00;
        end
    end
    // a stale value must not look valid, so show its inverse
    assign conv_data = conv_ack ? last : ~last;
endmodule

// [test/adc_sequencer_control_test.sv]
// --------------------------------------------
// sequencer bench
// --------------------------------------------
module adc_sequencer_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst_b = 0, standby = 0, bus_rd = 0, bus_wr = 0;
    logic dma_read = 0, ext_trigger_pin = 1, rd_d = 0;
    logic conv_req, conv_time_sel, conv_ack, conv_end_irq;
    logic [4:0] bus_addr = 5'h00;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, s;
    logic [2:0] conv_chan;
    logic [9:0] conv_data, d;
    logic [6:0] salt = 7'h00;
    logic [7:0] exp_q[$];
    int bad_count = 0, total_checks = 0, cycles = 0, seed = 53;
    always #25 core_clk = ~core_clk;
    adcsc_top adcsc_top_inst (.core_clk, .rst_b, .standby, .bus_addr,
        .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .dma_read,
        .ext_trigger_pin, .conv_req, .conv_chan, .conv_time_sel,
        .conv_ack, .conv_data, .conv_end_irq);
    adcsc_core_model adcsc_core_model_inst (.core_clk, .rst_b, .conv_req,
        .conv_chan, .conv_time_sel, .salt, .conv_ack, .conv_data);
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic [4:0] a, input logic [7:0] w, r);
        @(posedge core_clk);
        #2;
        bus_addr = a;
        bus_wdata = w;
        bus_rd = r[0];
        bus_wr = !r[0];
        @(posedge core_clk);
        #2;
        bus_rd = 0;
        bus_wr = 0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] w);
        acc(a, w, 8'h00);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(a, 8'h00, 8'h01);
    endtask
    task automatic acks(input int n);
        int k = 0;
        while (n > 0 && k < 2000) begin
            @(posedge core_clk);
            k++;
            if (conv_ack === 1'b1) n--;
        end
        if (n > 0) chk("ack", 8'h01, 8'h00);
        repeat (2) @(posedge core_clk);
        #2;
    endtask
    task automatic test_done();
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // read data is due one cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_d) chk("rdata", exp_q.pop_front(), bus_rdata);
        rd_d <= bus_rd;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        #2;
        rst_b = 1;
        rd(5'h10, 8'h00);
        rd(5'h12, 8'h07);
        rd(5'h00, 8'h00);
        rd(5'h14, 8'h00);
        wr(5'h12, 8'hff);
        rd(5'h12, 8'he7);
        wr(5'h10, 8'h20);
        rd(5'h10, 8'h20);
        chk("req", 8'h00, 8'(conv_req));
        wr(5'h10, 8'h00);
        wr(5'h12, 8'h07);
        for (int c = 0; c < 8; c++) begin
            salt = 7'($random(seed));
            d = {salt, 3'(c)};
            s = {4'h4, 1'(c % 2), 3'(c)};
            wr(5'h10, s | 8'h20);
            acks(1);
            chk("irq", 8'h01, 8'(conv_end_irq));
            chk("tsel", 8'(c % 2), 8'(conv_time_sel));
            rd(5'h10, s | 8'h80);
            wr(5'h10, s | 8'h80);
            rd(5'h10, s | 8'h80);
            wr(5'h10, s);
            rd(5'h10, s);
            chk("irq", 8'h00, 8'(conv_end_irq));
            rd(5'(c % 4 * 4), d[9:2]);
            rd(5'(c % 4 * 4 + 2), {d[1:0], 6'h00});
        end
        salt = 7'($random(seed));
        wr(5'h10, 8'h36);
        rd(5'h10, 8'h36);
        acks(3);
        chk("irq", 8'h00, 8'(conv_end_irq));
        rd(5'h10, 8'h96);
        for (int p = 0; p < 3; p++) begin
            d = {salt, 3'(p + 4)};
            rd(5'(p * 4), d[9:2]);
        end
        dma_read = 1;
        @(posedge core_clk);
        #2;
        dma_read = 0;
        rd(5'h10, 8'h16);
        wr(5'h12, 8'h27);
        wr(5'h10, 8'h71);
        acks(2);
        chk("irq", 8'h01, 8'(conv_end_irq));
        acks(2);
        rd(5'h10, 8'hf1);
        wr(5'h10, 8'h51);
        rd(5'h10, 8'h51);
        chk("req", 8'h00, 8'(conv_req));
        for (int t = 0; t < 4; t++) begin
            wr(5'h12, {2'(t), 6'h07});
            wr(5'h10, 8'h42);
            ext_trigger_pin = 0;
            repeat (4) @(posedge core_clk);
            #2;
            chk("req", 8'(t == 3), 8'(conv_req));
            ext_trigger_pin = 1;
            if (t == 3) begin
                acks(1);
                rd(5'h10, 8'hc2);
            end
        end
        standby = 1;
        @(posedge core_clk);
        #2;
        standby = 0;
        rd(5'h10, 8'h00);
        rd(5'h12, 8'h07);
        rd(5'h08, 8'h00);
        test_done();
    end
endmodule
